// ===== fdbc_pkg.sv
// constants for the five decade bcd counter with latches and digit multiplexer
package fdbc_pkg;

  // ----------------------------------------------------------------
  // clock and count rate
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ        = 50_000_000;
  localparam int unsigned EDGE_RATE_MAX_HZ  = 10_000_000;
  localparam int unsigned EDGE_PERIOD_MIN_CYCLES = (SYS_CLK_HZ / EDGE_RATE_MAX_HZ < 1) ? 1
                                                  : SYS_CLK_HZ / EDGE_RATE_MAX_HZ;

  // ----------------------------------------------------------------
  // decade layout
  // ----------------------------------------------------------------
  localparam int unsigned DIGIT_W      = 4;
  localparam int unsigned DECADE_COUNT = 5;
  localparam int unsigned OVL_IDX      = 4;
  localparam logic [3:0]  DIGIT_MAX    = 4'h9;
  localparam logic [3:0]  OVL_MAX      = 4'h1;
  localparam logic [3:0]  DIGIT_ZERO   = 4'h0;

  // ----------------------------------------------------------------
  // binary weights of the decades, count limits
  // ----------------------------------------------------------------
  localparam logic [14:0] WEIGHT_UNITS = 15'h0001;
  localparam logic [14:0] WEIGHT_TENS  = 15'h000a;
  localparam logic [14:0] WEIGHT_HUND  = 15'h0064;
  localparam logic [14:0] WEIGHT_THOU  = 15'h03e8;
  localparam logic [14:0] WEIGHT_OVL   = 15'h2710;
  localparam logic [14:0] COUNT_MAX    = 15'h4e1f;
  localparam logic [14:0] COUNT_OVL    = 15'h2710;
  localparam logic [14:0] COUNT_ZERO   = 15'h0000;

  // ----------------------------------------------------------------
  // values after reset, zero fill of the upper bus bits
  // ----------------------------------------------------------------
  localparam logic [3:0]  BUS_RST      = 4'h0;
  localparam logic        OE_B_RST     = 1'b1;
  localparam logic        CARRY_N_RST  = 1'b1;
  localparam logic        EDGE_RST     = 1'b0;
  localparam logic [1:0]  BUS_HI_ZERO  = 2'h0;

endpackage

// ===== fdbc_decade.sv
// one counting stage: clear, preload to its top digit, step with wrap
`timescale 1ns/1ns
`default_nettype none

module fdbc_decade
  import fdbc_pkg::*;
#(
  parameter logic [3:0] TOP = DIGIT_MAX
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       clear_i,
  input  wire logic       preload_i,
  input  wire logic       step_i,
  output var  logic [3:0] digit_o,
  output logic            at_top_o
);

  // ----------------------------------------------------------------
  // digit register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      digit_o <= DIGIT_ZERO;
    end
    else if (clear_i)
    begin
      digit_o <= DIGIT_ZERO;
    end
    else if (preload_i)
    begin
      digit_o <= TOP;
    end
    else if (step_i)
    begin
      digit_o <= at_top_o ? DIGIT_ZERO : digit_o + 4'h1;
    end
  end

  assign at_top_o = (digit_o == TOP);

endmodule

`default_nettype wire

// ===== fdbc_counter.sv
// five decade bcd counter with transfer latches, digit mux and carries
// Function
// - with clear and preload low, each rising count edge adds one; 19 999 wraps to zero
// - clear high forces count to zero, over count edge and preload
// - preload high with clear low sets count to 19 999
// - four decimal decades plus one overload stage, top count 19 999
// - copy enable high makes the latches follow the counter
// - output enable high drives the bus, low floats all four lines
// - select lines pick decade in binary order; top select picks overload
// - overload digit sits on two low bus bits, upper two driven low
// - all carry outputs are active low
// - decade two carry low while two lowest decades hold 9
// - decade three carry low while three lowest decades hold 9
// - decade four carry low while four lowest decades hold 9
// - preload high holds carries two to four high; released afterwards
// - overload carry low from count 10 000 until count is zero
// - bus shows the selected latch as positive logic bcd
// - carries exist for decades two to five only, none for units
// - count held indefinitely without edges; edges up to 10 MHz accepted
`timescale 1ns/1ns
`default_nettype none

module fdbc_counter
  import fdbc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       count_edge_in_i,
  input  wire logic       clear_in_i,
  input  wire logic       preload_in_i,
  input  wire logic       copy_enable_i,
  input  wire logic       digit_out_enable_i,
  input  wire logic [1:0] digit_sel_i,
  input  wire logic       overload_sel_i,
  output var  logic [3:0] bcd_digit_bus_o,
  output var  logic       bcd_digit_bus_oe_b_o,
  output var  logic       carry_decade_two_n_o,
  output var  logic       carry_decade_three_n_o,
  output var  logic       carry_decade_four_n_o,
  output var  logic       carry_overload_n_o
);

  logic       count_edge_prev;
  logic       count_rise;
  logic [3:0] digit        [0:DECADE_COUNT-1];
  logic       at_top       [0:DECADE_COUNT-1];
  logic       step         [0:DECADE_COUNT-1];
  logic [3:0] digit_latch  [0:DECADE_COUNT-1];
  logic [3:0] next_bus;
  logic       all_nine_two;
  logic       all_nine_three;
  logic       all_nine_four;
  logic [14:0] count_value;

  // ----------------------------------------------------------------
  // count edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_edge_prev <= EDGE_RST;
    end
    else
    begin
      count_edge_prev <= count_edge_in_i;
    end
  end

  assign count_rise = count_edge_in_i & ~count_edge_prev;

  // ----------------------------------------------------------------
  // decade chain
  // ----------------------------------------------------------------
  assign step[0] = count_rise;

  for (genvar i = 0; i < DECADE_COUNT; i++)
  begin : g_stage
    fdbc_decade #(
      .TOP ((i == OVL_IDX) ? OVL_MAX : DIGIT_MAX)
    ) u_stage (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .clear_i   (clear_in_i),
      .preload_i (preload_in_i),
      .step_i    (step[i]),
      .digit_o   (digit[i]),
      .at_top_o  (at_top[i])
    );
    if (i < OVL_IDX)
    begin : g_ripple
      assign step[i+1] = step[i] & at_top[i];
    end
  end

  // ----------------------------------------------------------------
  // carry outputs
  // ----------------------------------------------------------------
  assign all_nine_two   = at_top[0] & at_top[1];
  assign all_nine_three = all_nine_two & at_top[2];
  assign all_nine_four  = all_nine_three & at_top[3];

  // no carry exists for the units decade
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      carry_decade_two_n_o   <= CARRY_N_RST;
      carry_decade_three_n_o <= CARRY_N_RST;
      carry_decade_four_n_o  <= CARRY_N_RST;
      carry_overload_n_o     <= CARRY_N_RST;
    end
    else
    begin
      carry_decade_two_n_o   <= ~(all_nine_two & ~preload_in_i);
      carry_decade_three_n_o <= ~(all_nine_three & ~preload_in_i);
      carry_decade_four_n_o  <= ~(all_nine_four & ~preload_in_i);
      carry_overload_n_o     <= ~at_top[OVL_IDX];
    end
  end

  // ----------------------------------------------------------------
  // transfer latches
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int k = 0; k < DECADE_COUNT; k++)
      begin
        digit_latch[k] <= DIGIT_ZERO;
      end
    end
    else if (copy_enable_i)
    begin
      for (int k = 0; k < DECADE_COUNT; k++)
      begin
        digit_latch[k] <= digit[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // digit multiplexer and bus drive
  // ----------------------------------------------------------------
  always_comb
  begin
    next_bus = digit_latch[digit_sel_i];
    if (overload_sel_i)
    begin
      next_bus = {BUS_HI_ZERO, digit_latch[OVL_IDX][1:0]};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bcd_digit_bus_o      <= BUS_RST;
      bcd_digit_bus_oe_b_o <= OE_B_RST;
    end
    else
    begin
      bcd_digit_bus_o      <= next_bus;
      bcd_digit_bus_oe_b_o <= ~digit_out_enable_i;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  assign count_value = 15'(digit[0]) * WEIGHT_UNITS
                     + 15'(digit[1]) * WEIGHT_TENS
                     + 15'(digit[2]) * WEIGHT_HUND
                     + 15'(digit[3]) * WEIGHT_THOU
                     + 15'(digit[4]) * WEIGHT_OVL;

  default clocking dc @(posedge sys_clk_i);
  endclocking

  default disable iff (!rst_b_i);

  count_step_a: assert property (
    (count_rise && !clear_in_i && !preload_in_i && count_value != COUNT_MAX)
      |=> count_value == $past(count_value) + 15'h0001)
    else $error("count did not advance by one");

  count_wrap_a: assert property (
    (count_rise && !clear_in_i && !preload_in_i && count_value == COUNT_MAX)
      |=> count_value == COUNT_ZERO)
    else $error("count did not wrap to zero");

  clear_zero_a: assert property (
    clear_in_i |=> count_value == COUNT_ZERO)
    else $error("clear did not zero the count");

  preload_max_a: assert property (
    (!clear_in_i && preload_in_i) |=> count_value == COUNT_MAX)
    else $error("preload did not set top count");

  digit_range_a: assert property (
    digit[0] <= DIGIT_MAX && digit[1] <= DIGIT_MAX && digit[2] <= DIGIT_MAX
      && digit[3] <= DIGIT_MAX && digit[4] <= OVL_MAX)
    else $error("stage left its decimal range");

  count_hold_a: assert property (
    (!count_rise && !clear_in_i && !preload_in_i) |=> $stable(count_value))
    else $error("count changed without an edge");

  latch_follow_a: assert property (
    copy_enable_i |=> digit_latch[0] == $past(digit[0])
                   && digit_latch[1] == $past(digit[1])
                   && digit_latch[2] == $past(digit[2])
                   && digit_latch[3] == $past(digit[3])
                   && digit_latch[4] == $past(digit[4]))
    else $error("latches did not follow the counter");

  latch_hold_a: assert property (
    !copy_enable_i [*2] |-> $stable(digit_latch[0]) && $stable(digit_latch[1])
                         && $stable(digit_latch[2]) && $stable(digit_latch[3])
                         && $stable(digit_latch[4]))
    else $error("latches changed while frozen");

  bus_enable_a: assert property (
    (rst_b_i && digit_out_enable_i) |=> !bcd_digit_bus_oe_b_o ##0 $past(digit_out_enable_i))
    else $error("bus not driven while enabled");

  bus_float_a: assert property (
    !digit_out_enable_i |=> bcd_digit_bus_oe_b_o)
    else $error("bus driven while disabled");

  decade_sel_a: assert property (
    !overload_sel_i |=> bcd_digit_bus_o == $past(digit_latch[digit_sel_i]))
    else $error("wrong decade on the bus");

  overload_sel_a: assert property (
    overload_sel_i |=> bcd_digit_bus_o[3:2] == BUS_HI_ZERO
                    && bcd_digit_bus_o[1:0] == $past(digit_latch[OVL_IDX][1:0]))
    else $error("overload digit misplaced on the bus");

  carry_two_a: assert property (
    (digit[0] == DIGIT_MAX && digit[1] == DIGIT_MAX && !preload_in_i)
      |=> !carry_decade_two_n_o)
    else $error("decade two carry missing");

  carry_three_a: assert property (
    (count_value[14:0] != COUNT_MAX && digit[0] == DIGIT_MAX && digit[1] == DIGIT_MAX
      && digit[2] != DIGIT_MAX) |=> carry_decade_three_n_o && !$past(all_nine_three))
    else $error("decade three carry out of place");

  carry_four_a: assert property (
    ((count_value == COUNT_MAX || count_value == COUNT_MAX - COUNT_OVL) && !preload_in_i)
      |=> !carry_decade_four_n_o ##1 (carry_decade_four_n_o || $past(all_nine_four)))
    else $error("decade four carry wrong");

  carry_suppress_a: assert property (
    preload_in_i |=> carry_decade_two_n_o && carry_decade_three_n_o && carry_decade_four_n_o)
    else $error("carries not held high under preload");

  carry_ovl_set_a: assert property (
    count_value == COUNT_OVL |=> !carry_overload_n_o)
    else $error("overload carry not low at ten thousand");

  carry_ovl_clr_a: assert property (
    count_value == COUNT_ZERO |=> carry_overload_n_o)
    else $error("overload carry not high at zero");

  carry_two_high_a: assert property (
    !all_nine_two |=> carry_decade_two_n_o)
    else $error("decade two carry low without nines");

  carry_three_low_a: assert property (
    (all_nine_three && !preload_in_i) |=> !carry_decade_three_n_o)
    else $error("decade three carry missing");

  carry_four_low_a: assert property (
    (all_nine_four && !preload_in_i) |=> !carry_decade_four_n_o)
    else $error("decade four carry missing");

  carry_ovl_hold_a: assert property (
    digit[OVL_IDX] == OVL_MAX |=> !carry_overload_n_o)
    else $error("overload carry high above ten thousand");

  clear_priority_a: assert property (
    (clear_in_i && preload_in_i) |=> count_value == COUNT_ZERO && carry_decade_four_n_o)
    else $error("preload beat clear");

  wrap_c: cover property (
    count_value == COUNT_MAX ##1 count_value == COUNT_ZERO);

  preload_release_c: cover property (
    preload_in_i ##1 !preload_in_i ##1 !carry_decade_four_n_o);

  overload_reach_c: cover property (
    count_value == COUNT_OVL - 15'h0001 ##[1:20] count_value == COUNT_OVL);

  frozen_read_c: cover property (
    !copy_enable_i && count_rise ##1 digit_out_enable_i && overload_sel_i);

  ovl_carry_c: cover property (
    carry_overload_n_o ##1 !carry_overload_n_o);

endmodule

`default_nettype wire

// ===== fdbc_pulse_src.sv
// pulse source and bus wire model at the far side of the counter
`timescale 1ns/1ns
`default_nettype none

module fdbc_pulse_src
  import fdbc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] bus_i,
  input  wire logic       oe_b_i,
  output logic            count_edge_o,
  output logic [3:0]      bus_wire_o
);
  logic [3:0] phase;
  logic [3:0] last;
  logic [3:0] top;

  // ----------------------------------------------------------------
  // count edges, one rise per period
  // ----------------------------------------------------------------
  assign top = slow_i ? 4'h9 : 4'(EDGE_PERIOD_MIN_CYCLES);
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      phase <= 4'h0;
    else if (run_i || (phase != 4'h0))
      phase <= (phase >= top) ? 4'h0 : phase + 4'h1;
  end
  assign count_edge_o = (phase >= 4'h3);

  // ----------------------------------------------------------------
  // shared bus, floating lines show no stale value
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      last <= 4'h0;
    else if (!oe_b_i)
      last <= bus_i;
  end
  assign bus_wire_o = oe_b_i ? ~last : bus_i;
endmodule

`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the five decade bcd counter
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import fdbc_pkg::*;
;
  typedef struct {int n; logic slow; logic [14:0] cnt; logic [3:0] cy;} fdbc_row_t;
  fdbc_row_t   rows [5] = '{'{32'h9, 1'b1, 15'h0009, 4'hf}, '{32'h5a, 1'b0, 15'h0063, 4'he},
                            '{32'h384, 1'b0, 15'h03e7, 4'hc}, '{32'h1, 1'b1, 15'h03e8, 4'hf},
                            '{32'h2328, 1'b0, 15'h2710, 4'h7}};
  logic [14:0] wt [5] = '{WEIGHT_UNITS, WEIGHT_TENS, WEIGHT_HUND, WEIGHT_THOU, WEIGHT_OVL};
  logic        sys_clk, rst_b, count_edge, clear_in, preload_in, copy_en, out_en, ovl_sel, run, slow;
  logic        oe_b, c2, c3, c4, c5;
  logic [1:0]  dsel;
  logic [3:0]  bus, wire_v, d;
  int          errors, compares;

  fdbc_counter i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .count_edge_in_i(count_edge),
    .clear_in_i(clear_in), .preload_in_i(preload_in), .copy_enable_i(copy_en),
    .digit_out_enable_i(out_en), .digit_sel_i(dsel), .overload_sel_i(ovl_sel),
    .bcd_digit_bus_o(bus), .bcd_digit_bus_oe_b_o(oe_b), .carry_decade_two_n_o(c2),
    .carry_decade_three_n_o(c3), .carry_decade_four_n_o(c4), .carry_overload_n_o(c5));
  fdbc_pulse_src i_src (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .run_i(run), .slow_i(slow),
    .bus_i(bus), .oe_b_i(oe_b), .count_edge_o(count_edge), .bus_wire_o(wire_v));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [14:0] seen, input logic [14:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic pulses(input int n, input logic s);
    @(posedge sys_clk);
    slow <= s;
    run <= 1'b1;
    repeat (n) @(posedge count_edge);
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic dig(input logic [2:0] s, output logic [3:0] v);
    @(posedge sys_clk);
    dsel <= s[1:0];
    ovl_sel <= s[2];
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    v = wire_v;
  endtask

  task automatic chkcnt(input logic [14:0] exp);
    logic [14:0] v;
    logic [3:0]  dd;
    v = 15'h0000;
    for (int i = 0; i < 5; i++)
    begin
      dig(3'(i), dd);
      v = v + 15'(dd) * wt[i];
    end
    chk("count", v, exp);
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if ((errors == 0) && (compares > 0))
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    #1_600_000;
    errors++;
    summarize();
  end

  initial
  begin
    {rst_b, clear_in, preload_in, ovl_sel, run, slow, dsel} = 8'h00;
    {copy_en, out_en} = 2'h3;
    errors = 0;
    compares = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("reset", 15'({oe_b, c5, c4, c3, c2, bus}), 15'h01f0);
    foreach (rows[i])
    begin
      pulses(rows[i].n, rows[i].slow);
      chk("carries", 15'({c5, c4, c3, c2}), 15'(rows[i].cy));
      chkcnt(rows[i].cnt);
      chk("oe_b", 15'(oe_b), 15'h0000);
    end
    @(posedge sys_clk);
    preload_in <= 1'b1;
    pulses(2, 1'b0);
    chk("carries", 15'({c5, c4, c3, c2}), 15'h0007);
    chkcnt(COUNT_MAX);
    dig(3'h7, d);
    chk("overload", 15'(d), 15'h0001);
    @(posedge sys_clk);
    preload_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("carries", 15'({c5, c4, c3, c2}), 15'h0000);
    pulses(1, 1'b0);
    chk("carries", 15'({c5, c4, c3, c2}), 15'h000f);
    chkcnt(COUNT_ZERO);
    @(posedge sys_clk);
    clear_in <= 1'b1;
    preload_in <= 1'b1;
    pulses(3, 1'b0);
    chkcnt(COUNT_ZERO);
    @(posedge sys_clk);
    clear_in <= 1'b0;
    preload_in <= 1'b0;
    copy_en <= 1'b0;
    pulses(7, 1'b1);
    chkcnt(COUNT_ZERO);
    @(posedge sys_clk);
    copy_en <= 1'b1;
    chkcnt(15'h0007);
    @(posedge sys_clk);
    out_en <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("oe_b", 15'(oe_b), 15'h0001);
    summarize();
  end
endmodule

`default_nettype wire
